/* rx_descriptor_error_status_tb_top.sv */
// Self-checking bench for the receive status writer.
// Assumes the memory model paces wb_ready; expected words come from the flags.
`timescale 1ns/1ps
module rx_descriptor_error_status_tb_top;
  import rxdes_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic seg_valid = 1'b0;
  rxdes_seg_t seg_data = '0;
  logic seg_ready;
  logic wb_valid_q;
  logic [31:0] wb_word_q;
  logic wb_ready;
  logic [1:0] stall_mode = 2'd0;
  logic [31:0] exp_q[$]; // Expected words, oldest first
  int err_count = 0;
  int tests_run = 0;
  always #2.5 mclk = ~mclk;
  rxdes_status_writer u_rxdes_status_writer (.mclk(mclk), .rst(rst), .seg_valid(seg_valid),
    .seg_data(seg_data), .seg_ready(seg_ready), .wb_valid_q(wb_valid_q),
    .wb_word_q(wb_word_q), .wb_ready(wb_ready));
  rxdes_mem_model u_rxdes_mem_model (.mclk(mclk), .rst(rst), .stall_mode(stall_mode),
    .wb_valid_q(wb_valid_q), .wb_word_q(wb_word_q), .wb_ready(wb_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Status word as the host should read it
  function automatic logic [31:0] exp_word(input rxdes_seg_t s);
    logic [31:0] w;
    w = WORD_RST;
    if (s.last_seg) begin
      w[LAST_BIT] = 1'b1;
      w[CRC_BIT] = s.crc_err;
      w[RXERR_BIT] = s.rx_err;
      w[WDOG_BIT] = s.wdog_to;
      w[LCOL_BIT] = s.late_coll;
      w[GIANT_BIT] = s.giant_csum;
      w[OVF_BIT] = s.fifo_ovf;
      w[TRUNC_BIT] = s.no_next_desc;
      w[SRC_FAIL_BIT] = s.sa_fail;
      w[TYPE_BIT] = (s.len_type >= ETH2_MIN_TYPE);
      w[LEN_ERR_BIT] = !w[TYPE_BIT] && !s.crc_err && (s.payload_len != s.len_type);
      w[SUMMARY_BIT] = |(w & SUMMARY_MASK);
    end
    return w;
  endfunction : exp_word
  // Offer one summary, hold it until taken or the bound runs out
  task automatic send(input rxdes_seg_t s, input int lim, output bit ok);
    ok = 1'b0;
    seg_valid <= 1'b1;
    seg_data <= s;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge mclk);
      if (seg_ready === 1'b1) ok = 1'b1;
    end
    if (ok) exp_q.push_back(exp_word(s));
  endtask : send
  task automatic put(input rxdes_seg_t s);
    bit ok;
    send(s, 200, ok);
    if (!ok) begin
      check("seg_timeout", 32'h0000_0000, 32'h0000_0001);
      final_report();
    end
  endtask : put
  // Release the source and wait for every word to come back
  task automatic drain(input string name);
    int n;
    seg_valid <= 1'b0;
    for (n = 0; n < 3000 && (exp_q.size() != 0 || wb_valid_q !== 1'b0); n++) @(posedge mclk);
    if (n == 3000) begin
      check("drain_timeout", 32'h0000_0000, 32'h0000_0001);
      final_report();
    end
    $display("Test %s done", name);
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: every accepted word matches the oldest note
  always @(posedge mclk) begin
    if (!rst && wb_valid_q === 1'b1 && wb_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra_word", wb_word_q, 32'hFFFF_FFFF);
      else check("status_word", wb_word_q, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rxdes_seg_t s;
    bit ok;
    int i;
    void'($urandom(95410));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Each error flag alone in a last-segment descriptor
    for (i = 0; i < 8; i++) begin
      s = {1'b1, 8'h00, 16'h0040, 16'h0040};
      s[39-i] = 1'b1;
      put(s);
    end
    put({1'b0, 8'hFF, 16'h0040, 16'h0041});
    put({1'b1, 8'h00, 16'h0040, 16'h0050});
    put({1'b1, 8'h80, 16'h0040, 16'h0050});
    put({1'b1, 8'h00, 16'h0600, 16'h0010});
    put({1'b1, 8'h00, 16'h05FF, 16'h0010});
    drain("directed");
    // Random summaries, memory side stalling at random
    stall_mode <= 2'd1;
    for (i = 0; i < 60; i++) put(rxdes_seg_t'(41'({$urandom(), $urandom()})));
    drain("random");
    // Fill the buffer until it refuses, then drain it
    stall_mode <= 2'd2;
    ok = 1'b1;
    for (i = 0; i < 30 && ok; i++) begin
      s = rxdes_seg_t'(41'({$urandom(), $urandom()}));
      send(s, 40, ok);
    end
    check("refused", {31'h0, ok}, 32'h0000_0000);
    // Full buffer plus the word held by the writer, plus the refused try
    check("depth_reached", i, SEG_FIFO_DEPTH + 2);
    stall_mode <= 2'd1;
    put(s);
    drain("fill");
    final_report();
  end
endmodule : rx_descriptor_error_status_tb_top

/* rxdes_fifo.sv */
// Synchronous FIFO holding segment summaries until the writer is free.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rxdes_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW:0] wr_ptr_q;           // Write pointer with wrap bit
  logic [AW:0] rd_ptr_q;           // Read pointer with wrap bit
  logic push;
  logic pop;

  // Full when pointers match except for the wrap bit
  assign in_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data = mem[rd_ptr_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write; no reset needed, reads are gated by out_valid
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : rxdes_fifo

/* rxdes_mem_model.sv */
// Descriptor memory model: takes status writebacks from the writer.
// Assumes one clock with the writer and a synchronous active-high reset.
`timescale 1ns/1ps
module rxdes_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pacing: 0 always ready, 1 random stalls, 2 stalled
  input wire logic [1:0] stall_mode,
  // Writeback from the writer
  input wire logic wb_valid_q,
  input wire logic [31:0] wb_word_q,
  output logic wb_ready
);
  ////////////////////////////////////////////////////////////////////////////
  // Ready changes only after an edge; a word is whole once taken
  always @(posedge mclk) begin
    if (rst) begin
      wb_ready <= 1'b0;
    end else begin
      // Random pacing exercises the held-word path
      wb_ready <= (stall_mode == 2'd0) || ((stall_mode == 2'd1) && ($urandom % 3 != 0));
    end
  end
endmodule : rxdes_mem_model

/* rxdes_pkg.sv */
// Package for the receive descriptor status writer: bit positions, masks,
// reset values and the packed carriers shared by the writer and its testbench.
// Assumes the MAC side supplies one segment summary per closed descriptor.
package rxdes_pkg;

  // Descriptor word 0 bit positions
  localparam int unsigned OWN_BIT = 31;
  localparam int unsigned SUMMARY_BIT = 15;
  localparam int unsigned TRUNC_BIT = 14;
  localparam int unsigned SRC_FAIL_BIT = 13;
  localparam int unsigned LEN_ERR_BIT = 12;
  localparam int unsigned OVF_BIT = 11;
  localparam int unsigned LAST_BIT = 8;
  localparam int unsigned GIANT_BIT = 7;
  localparam int unsigned LCOL_BIT = 6;
  localparam int unsigned TYPE_BIT = 5;
  localparam int unsigned WDOG_BIT = 4;
  localparam int unsigned RXERR_BIT = 3;
  localparam int unsigned CRC_BIT = 1;

  // Bits that feed the error summary: 1, 3, 4, 6, 7, 11, 14
  localparam logic [31:0] SUMMARY_MASK = 32'h0000_48DA;

  // Length/type values at or above this mark an Ethernet II frame
  localparam logic [15:0] ETH2_MIN_TYPE = 16'h0600;

  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Segment FIFO depth in words
  localparam int unsigned SEG_FIFO_DEPTH = 16;

  // One closed descriptor as reported by the receive path
  typedef struct packed {
    logic last_seg;      // Buffers hold the final part of the frame
    logic crc_err;       // Frame check sequence failed
    logic rx_err;        // Receive error seen during the frame
    logic wdog_to;       // Receive watchdog expired
    logic late_coll;     // Late collision in half duplex
    logic giant_csum;    // Giant frame or IP header checksum error
    logic fifo_ovf;      // Frame damaged by receive FIFO overflow
    logic no_next_desc;  // Frame did not fit and next descriptor is CPU owned
    logic sa_fail;       // Source address filter rejected the frame
    logic [15:0] len_type;     // Length/type field of the frame
    logic [15:0] payload_len;  // Counted payload bytes
  } rxdes_seg_t;

  // Writer state
  typedef enum logic {
    RXDES_IDLE,
    RXDES_WRITE
  } rxdes_state_t;

endpackage : rxdes_pkg

/* rxdes_status_writer.sv */
// Receive descriptor status writer: turns segment summaries into the
// status word that closes a receive descriptor.
// Assumes the memory side takes a word on wb_valid and wb_ready both high.
//
// Summary of operation
// - Summary bit 15 built from bits 1,3,4,6,7,11,14
// - Summary is OR of all contributing errors
// - Bit 14 set on truncation, next descriptor unowned
// - Descriptor error only meaningful with last segment
// - Bit 13 set on source filter failure
// - Bit 12 set when length field mismatches
// - Length error valid only Ethernet 802.3, no CRC
// - Bit 11 set on receive FIFO overflow
// - Last segment bit only on final descriptor
// - Frame type set when length/type at least 1536
`timescale 1ns/1ps
module rxdes_status_writer
  import rxdes_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Segment summaries from the receive path
  input wire logic seg_valid,
  input wire rxdes_seg_t seg_data,
  output logic seg_ready,
  // Status writeback toward the descriptor in memory
  output logic wb_valid_q,
  output logic [31:0] wb_word_q,
  input wire logic wb_ready
);

  ////////////////////////////////////////////////////////////////////////
  // Segment buffer

  logic fifo_in_ready;      // FIFO space for one more summary
  logic fifo_valid;         // Summary waiting
  logic fifo_ready;         // Writer takes a summary
  logic [$bits(rxdes_seg_t)-1:0] fifo_bits;
  rxdes_seg_t head_seg;     // Oldest summary
  logic seg_ready_q;        // Registered copy of FIFO space

  // Buffer decouples the MAC from slow descriptor writes
  rxdes_fifo #(
    .WIDTH($bits(rxdes_seg_t)),
    .DEPTH(SEG_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(seg_valid && seg_ready_q),
    .in_ready(fifo_in_ready),
    .in_data(seg_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_bits)
  );

  assign head_seg = rxdes_seg_t'(fifo_bits);

  // Ready is registered, so it lags one cycle; dropping it for a cycle
  // after each take stops a second push into a slot the first one filled
  always_ff @(posedge mclk) begin
    if (rst) begin
      seg_ready_q <= 1'b0;
    end else begin
      seg_ready_q <= fifo_in_ready && !(seg_valid && seg_ready_q);
    end
  end

  assign seg_ready = seg_ready_q;

  ////////////////////////////////////////////////////////////////////////
  // Status word assembly

  rxdes_state_t state_q;
  rxdes_seg_t seg_q;        // Summary behind the word now offered
  logic [31:0] word_d;      // Word built from the head summary
  logic frame_eth2;         // Length/type marks Ethernet II
  logic len_bad;            // Counted length differs from field

  always_comb begin
    word_d = WORD_RST;
    frame_eth2 = (head_seg.len_type >= ETH2_MIN_TYPE);
    len_bad = (head_seg.payload_len != head_seg.len_type);
    // Frame-level flags belong only to the closing descriptor
    if (head_seg.last_seg) begin
      word_d[LAST_BIT] = 1'b1;
      word_d[CRC_BIT] = head_seg.crc_err;
      word_d[RXERR_BIT] = head_seg.rx_err;
      word_d[WDOG_BIT] = head_seg.wdog_to;
      word_d[LCOL_BIT] = head_seg.late_coll;
      word_d[GIANT_BIT] = head_seg.giant_csum;
      word_d[TYPE_BIT] = frame_eth2;
      word_d[OVF_BIT] = head_seg.fifo_ovf;
      word_d[TRUNC_BIT] = head_seg.no_next_desc;
      word_d[SRC_FAIL_BIT] = head_seg.sa_fail;
      // Mismatch only reported where the host may trust it
      word_d[LEN_ERR_BIT] = len_bad && !frame_eth2 && !head_seg.crc_err;
    end
    word_d[SUMMARY_BIT] = |(word_d & SUMMARY_MASK);
    word_d[OWN_BIT] = 1'b0;
  end

  assign fifo_ready = (state_q == RXDES_IDLE);

  // Writer sequencing: take a summary, hold the word until accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= RXDES_IDLE;
    end else begin
      case (state_q)
        RXDES_IDLE: begin
          if (fifo_valid) begin
            state_q <= RXDES_WRITE;
          end
        end
        RXDES_WRITE: begin
          if (wb_ready) begin
            state_q <= RXDES_IDLE;
          end
        end
        default: begin
          state_q <= RXDES_IDLE;
        end
      endcase
    end
  end

  // Word and summary captured together so all flags land in one write
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_word_q <= WORD_RST;
      seg_q <= '0;
    end else if (fifo_valid && fifo_ready) begin
      wb_word_q <= word_d;
      seg_q <= head_seg;
    end
  end

  // Writeback strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_valid_q <= 1'b0;
    end else if (fifo_valid && fifo_ready) begin
      wb_valid_q <= 1'b1;
    end else if (wb_ready) begin
      wb_valid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_take;
    fifo_valid && fifo_ready;
  endsequence

  sequence s_offer;
    wb_valid_q && !wb_word_q[OWN_BIT];
  endsequence

  a_summary_or: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q |-> (wb_word_q[SUMMARY_BIT] == |(wb_word_q & SUMMARY_MASK)))
    else $error("error summary does not match its sources");

  a_summary_any: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg && (seg_q.crc_err || seg_q.fifo_ovf || seg_q.rx_err)
      |-> wb_word_q[SUMMARY_BIT])
    else $error("error summary missed a set error");

  a_trunc_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg |-> (wb_word_q[TRUNC_BIT] == seg_q.no_next_desc))
    else $error("descriptor error flag wrong");

  a_trunc_last: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && !wb_word_q[LAST_BIT] |-> !wb_word_q[TRUNC_BIT])
    else $error("descriptor error outside last segment");

  a_sa_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg |-> (wb_word_q[SRC_FAIL_BIT] == seg_q.sa_fail))
    else $error("source filter flag wrong");

  a_len_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg && !seg_q.crc_err && (seg_q.len_type < ETH2_MIN_TYPE)
      |-> (wb_word_q[LEN_ERR_BIT] == (seg_q.payload_len != seg_q.len_type)))
    else $error("length error flag wrong");

  a_len_valid: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && wb_word_q[LEN_ERR_BIT] |-> !wb_word_q[TYPE_BIT] && !wb_word_q[CRC_BIT])
    else $error("length error with frame type or crc error");

  a_ovf_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg |-> (wb_word_q[OVF_BIT] == seg_q.fifo_ovf))
    else $error("overflow flag wrong");

  a_last_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q |-> (wb_word_q[LAST_BIT] == seg_q.last_seg))
    else $error("last segment flag wrong");

  a_type_flag: assert property (@(posedge mclk) disable iff (rst)
    wb_valid_q && seg_q.last_seg
      |-> (wb_word_q[TYPE_BIT] == (seg_q.len_type >= ETH2_MIN_TYPE)))
    else $error("frame type flag wrong");

  a_one_write: assert property (@(posedge mclk) disable iff (rst)
    s_take |=> ((s_offer ##0 (wb_valid_q && !wb_ready)) |=> (s_offer and $stable(wb_word_q))))
    else $error("status word not held whole until accepted");

endmodule : rxdes_status_writer
